// ===== src/gdf_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "gdf_params.svh"

module gdf_top
   import gdf_pkg::*;
#(
   parameter int BLOCK_CYC  = `GDF_BLOCK_MS * `GDF_CLK_MHZ * 1000,
   parameter int REPORT_CYC = `GDF_REPORT_MS * `GDF_CLK_MHZ * 1000,
   parameter int XOFF_CYC   = `GDF_XOFF_MS * `GDF_CLK_MHZ * 1000,
   parameter int XREL_CYC   = XOFF_CYC * `GDF_XREL_MS / `GDF_XOFF_MS, // Scales with XOFF_CYC
   parameter int ERRCLR_CYC = `GDF_ERRCLR_US * `GDF_CLK_MHZ,
   parameter int PWRUP_CYC  = `GDF_PWRUP_MS * `GDF_CLK_MHZ * 1000
) (
   input  wire logic        mclk,                    // 125 MHz device clock
   input  wire logic        rst,                     // Sync reset, high
   input  wire logic        optical_drive_in_first,  // Drive A, light on = 1
   input  wire logic        optical_drive_in_second, // Drive B / enable
   input  wire logic        operating_select_jumper, // 0 direct, 1 half-bridge
   input  wire logic [1:0]  desat_in,                // Vce above threshold
   input  wire logic [1:0]  uvlo_in,                 // Supply undervoltage
   input  wire logic [11:0] paddr,                   // APB address
   input  wire logic        psel,                    // APB select
   input  wire logic        penable,                 // APB enable
   input  wire logic        pwrite,                  // APB write
   input  wire logic [31:0] pwdata,                  // APB write data
   output logic      [31:0] prdata,                  // APB read data
   output logic             pready,                  // APB ready
   output logic             pslverr,                 // APB error
   output logic      [1:0]  gate_on,                 // Gate drive, 1 = on
   output logic      [1:0]  status_light             // Status, 1 = light on
);

   // ==========================================================
   // Derived sizes and elaboration checks
   localparam int ACK_CYC  = `GDF_ACK_CYC;
   localparam int RESP_CYC = `GDF_RESP_CYC;
   localparam int DEAD_CYC = `GDF_DEAD_CYC;
   localparam int RW       = $clog2(REPORT_CYC + 1);

   generate
      if (XOFF_CYC + XREL_CYC > REPORT_CYC || XOFF_CYC < 1 || XREL_CYC < 1) begin : g_bad
         $error("gdf_top: cross-channel window must fit in the report time");
      end
   endgenerate

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // Register decode shared by reads and writes
   function automatic logic reg_sel(input logic [11:0] a, input logic [11:0] ofs);
      reg_sel = (a[11:2] == ofs[11:2]);
   endfunction : reg_sel

   // ==========================================================
   // Pin synchronisation
   logic [6:0] pin_s;
   gdf_optin_s opt;
   logic [1:0] desat_s;
   logic [1:0] uv_s;

   gdf_sync #(.W(7)) u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    ({uvlo_in, desat_in, operating_select_jumper,
              optical_drive_in_first, optical_drive_in_second}),
      .q    (pin_s)
   );

   assign opt     = gdf_optin_s'(pin_s[2:0]);
   assign desat_s = pin_s[4:3];
   assign uv_s    = pin_s[6:5];

   // ==========================================================
   // Drive request per channel
   logic [1:0] req;
   logic [1:0] req_prev_q;
   logic [1:0] edge_w;

   // Mode decides what each optical input means
   always_comb begin
      if (opt.half) begin
         req[0] = opt.second & ~opt.first;
         req[1] = opt.second & opt.first;
      end else begin
         req = {opt.second, opt.first};
      end
   end

   // Previous request, for edge detection
   always_ff @(posedge mclk) begin
      if (rst) begin
         req_prev_q <= 2'b00;
      end else begin
         req_prev_q <= req;
      end
   end

   assign edge_w = req ^ req_prev_q;

   // ==========================================================
   // Power-up fault indication
   logic pwr_arm_q;
   logic pwr_busy;
   logic pwr_hold;

   // One start pulse right after reset release
   always_ff @(posedge mclk) begin
      if (rst) begin
         pwr_arm_q <= 1'b1;
      end else begin
         pwr_arm_q <= 1'b0;
      end
   end

   gdf_timer #(.LEN(PWRUP_CYC)) u_pwr (
      .mclk    (mclk),
      .rst     (rst),
      .start   (pwr_arm_q),
      .busy    (pwr_busy),
      .elapsed ()
   );

   assign pwr_hold = pwr_arm_q | pwr_busy;

   // ==========================================================
   // Software control register
   logic ctrl_softoff_q;
   logic apb_acc;
   logic apb_done;

   assign apb_acc  = psel & penable & ~pready;
   assign apb_done = psel & penable & pready;

   // Write takes effect only at the edge where pready is seen high
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_softoff_q <= `GDF_CTRL_RST;
      end else if (apb_done && pwrite && reg_sel(paddr, `GDF_CTRL_OFS)) begin
         ctrl_softoff_q <= pwdata[`GDF_CTRL_SOFTOFF];
      end
   end

   // ==========================================================
   // Per-channel state
   gdf_state_e       st_q [2];
   logic [1:0]       gate_q;
   logic [1:0]       gate_prev_q;
   logic [1:0]       stat_q;
   logic [1:0]       gate_d;
   logic [1:0]       stat_d;
   logic [1:0]       fault_w;
   logic [1:0]       allow;
   logic [1:0]       xforce;
   logic [1:0]       rep_start;
   logic [1:0]       dead_start;
   logic [1:0]       blank_start;
   logic [1:0]       ack_busy;
   logic [1:0]       dead_busy;
   logic [1:0]       blank_busy;
   logic [1:0]       blk_busy;
   logic [1:0]       rep_busy;
   logic [1:0]       clr_busy;
   logic [RW-1:0]    rep_el [2];

   generate
      for (genvar i = 0; i < 2; i++) begin : g_ch
         localparam int O = 1 - i;

         // Timer starts
         assign dead_start[i]  = req[i] & ~req_prev_q[i] & opt.half;
         assign blank_start[i] = gate_q[i] & ~gate_prev_q[i];
         assign rep_start[i]   = edge_w[i] & (st_q[i] == GDF_PEND);

         // Undervoltage is per channel; desat only after the blanking time
         assign fault_w[i] = uv_s[i]
                           | (desat_s[i] & gate_q[i] & ~blank_start[i]
                              & ~blank_busy[i]);

         // Dead time holds off turn-on only in half-bridge mode
         assign allow[i] = req[i] & ~(opt.half & (dead_start[i] | dead_busy[i]));

         // Healthy side is dropped while the other's report is in its late window
         assign xforce[i] = rep_busy[O]
                          & (rep_el[O] >= RW'(XOFF_CYC))
                          & (rep_el[O] < RW'(XOFF_CYC + XREL_CYC));

         gdf_timer #(.LEN(ACK_CYC)) u_ack (
            .mclk (mclk), .rst (rst), .start (edge_w[i]),
            .busy (ack_busy[i]), .elapsed ()
         );

         gdf_timer #(.LEN(DEAD_CYC)) u_dead (
            .mclk (mclk), .rst (rst), .start (dead_start[i]),
            .busy (dead_busy[i]), .elapsed ()
         );

         gdf_timer #(.LEN(RESP_CYC)) u_blank (
            .mclk (mclk), .rst (rst), .start (blank_start[i]),
            .busy (blank_busy[i]), .elapsed ()
         );

         gdf_timer #(.LEN(BLOCK_CYC)) u_block (
            .mclk (mclk), .rst (rst), .start (fault_w[i]),
            .busy (blk_busy[i]), .elapsed ()
         );

         gdf_timer #(.LEN(REPORT_CYC)) u_rep (
            .mclk (mclk), .rst (rst), .start (rep_start[i]),
            .busy (rep_busy[i]), .elapsed (rep_el[i])
         );

         gdf_timer #(.LEN(ERRCLR_CYC)) u_clr (
            .mclk (mclk), .rst (rst), .start (rep_start[i]),
            .busy (clr_busy[i]), .elapsed ()
         );

         // Fault sequence: detect, wait for drive change, latch, clear
         always_ff @(posedge mclk) begin
            if (rst) begin
               st_q[i] <= GDF_RUN;
            end else begin
               case (st_q[i])
                  GDF_RUN: begin
                     if (fault_w[i]) begin
                        st_q[i] <= GDF_PEND;
                     end
                  end
                  GDF_PEND: begin
                     if (edge_w[i]) begin
                        st_q[i] <= GDF_LATCH;
                     end
                  end
                  GDF_LATCH: begin
                     if (!clr_busy[i]) begin
                        if (fault_w[i]) begin
                           st_q[i] <= GDF_PEND;
                        end else if (blk_busy[i]) begin
                           st_q[i] <= GDF_HOLD;
                        end else begin
                           st_q[i] <= GDF_RUN;
                        end
                     end
                  end
                  GDF_HOLD: begin
                     if (fault_w[i]) begin
                        st_q[i] <= GDF_PEND;
                     end else if (!blk_busy[i]) begin
                        st_q[i] <= GDF_RUN;
                     end
                  end
                  default: begin
                     st_q[i] <= GDF_RUN;
                  end
               endcase
            end
         end

         // Gate only in run state; a fault cuts it in the same cycle
         assign gate_d[i] = (st_q[i] == GDF_RUN) & ~fault_w[i]
                          & ~blk_busy[i] & allow[i] & ~xforce[i]
                          & ~ctrl_softoff_q & ~pwr_hold;

         // Light off for power-up, acknowledge and report
         assign stat_d[i] = ~(pwr_hold | edge_w[i] | ack_busy[i]
                              | rep_busy[i] | rep_start[i]);

         // Output flops
         always_ff @(posedge mclk) begin
            if (rst) begin
               gate_q[i]      <= 1'b0;
               gate_prev_q[i] <= 1'b0;
               stat_q[i]      <= 1'b0;
            end else begin
               gate_q[i]      <= gate_d[i];
               gate_prev_q[i] <= gate_q[i];
               stat_q[i]      <= stat_d[i];
            end
         end

         a_ack_pulse: assert property (edge_w[i] |=> !stat_q[i] [*8])
            else $error("acknowledge pulse too short");
         a_fault_off: assert property (fault_w[i] |=> !gate_q[i])
            else $error("gate on after fault");
         a_block_hold: assert property (blk_busy[i] |=> !gate_q[i])
            else $error("gate on during blocking");
         a_report_cause: assert property ($rose(rep_busy[i])
               |-> $past(st_q[i] == GDF_PEND && edge_w[i]))
            else $error("report without pending fault and edge");
         a_report_dark: assert property ($rose(rep_busy[i])
               |-> (!stat_q[i] && rep_busy[i]) [*8])
            else $error("status light on during report");
         a_cross_off: assert property (xforce[i] |=> !gate_q[i])
            else $error("healthy channel not forced off");
         a_uv_block: assert property (uv_s[i]
               |=> (st_q[i] != GDF_RUN && !gate_q[i] && blk_busy[i]))
            else $error("undervoltage did not block channel");
         a_blank_mask: assert property ((blank_busy[i] && !uv_s[i])
               |-> !fault_w[i])
            else $error("desaturation seen inside blanking");
         a_err_clear: assert property ((st_q[i] == GDF_LATCH && !clr_busy[i])
               |=> st_q[i] != GDF_LATCH)
            else $error("latched error not cleared");
         a_hb_dead: assert property ((opt.half && req[i] && !req_prev_q[i])
               |=> !gate_q[i] [*2])
            else $error("turn-on without dead time");
      end
   endgenerate

   a_pwr_dark: assert property (pwr_hold |=> stat_q == 2'b00)
      else $error("status light on during power-up");
   a_hb_enable: assert property ((opt.half && !opt.second)
         |=> gate_q == 2'b00)
      else $error("gate on with half-bridge enable off");

   assign gate_on      = gate_q;
   assign status_light = stat_q;

   // ==========================================================
   // APB slave: one wait state, answer registered
   gdf_stat_s stat_img;
   logic      pready_q;
   logic      pslverr_q;
   logic [31:0] prdata_q;

   always_comb begin
      stat_img.pwrup = pwr_hold;
      stat_img.half  = opt.half;
      stat_img.gate  = gate_q;
      stat_img.light = stat_q;
      for (int k = 0; k < 2; k++) begin
         stat_img.pend[k]  = (st_q[k] == GDF_PEND);
         stat_img.err[k]   = (st_q[k] == GDF_LATCH);
         stat_img.block[k] = blk_busy[k];
      end
   end

   // Ready rises the cycle after the access phase starts
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= apb_acc;
         pslverr_q <= apb_acc & ~(reg_sel(paddr, `GDF_CTRL_OFS)
                                  | reg_sel(paddr, `GDF_STAT_OFS));
         if (apb_acc && !pwrite) begin
            if (reg_sel(paddr, `GDF_CTRL_OFS)) begin
               prdata_q <= {31'h0000_0000, ctrl_softoff_q};
            end else if (reg_sel(paddr, `GDF_STAT_OFS)) begin
               prdata_q <= {20'h0_0000, stat_img};
            end else begin
               prdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

endmodule : gdf_top

// ===== include/gdf_params.svh
`ifndef GDF_PARAMS_SVH
`define GDF_PARAMS_SVH

// ==========================================================
// Clock rate
`define GDF_CLK_MHZ       125

// ==========================================================
// Durations, each in its own unit
`define GDF_ACK_NS        1000
`define GDF_RESP_NS       4000
`define GDF_DEAD_NS       3000
`define GDF_BLOCK_MS      1000
`define GDF_REPORT_MS     12
`define GDF_XOFF_MS       8
`define GDF_XREL_MS       4
`define GDF_ERRCLR_US     3500
`define GDF_PWRUP_MS      8

// ==========================================================
// Cycle counts below the parameter threshold
`define GDF_ACK_CYC       (`GDF_ACK_NS * `GDF_CLK_MHZ / 1000)
`define GDF_RESP_CYC      (`GDF_RESP_NS * `GDF_CLK_MHZ / 1000)
`define GDF_DEAD_CYC      (`GDF_DEAD_NS * `GDF_CLK_MHZ / 1000)

// ==========================================================
// Register map (byte offsets) and reset values
`define GDF_CTRL_OFS      12'h000
`define GDF_STAT_OFS      12'h004
`define GDF_CTRL_RST      1'b0

// ==========================================================
// Field positions
`define GDF_CTRL_SOFTOFF  0
`define GDF_STAT_GATE     0
`define GDF_STAT_LIGHT    2
`define GDF_STAT_ERR      4
`define GDF_STAT_BLOCK    6
`define GDF_STAT_PEND     8
`define GDF_STAT_HALF     10
`define GDF_STAT_PWRUP    11
`define GDF_STAT_W        12

`endif

// ===== include/gdf_pkg.sv
package gdf_pkg;

   // ==========================================================
   // Channel fault state, Gray along the fault path
   typedef enum logic [1:0] {
      GDF_RUN   = 2'b00,
      GDF_PEND  = 2'b01,
      GDF_LATCH = 2'b11,
      GDF_HOLD  = 2'b10
   } gdf_state_e;

   // Synchronised optical and jumper inputs
   typedef struct packed {
      logic half;
      logic first;
      logic second;
   } gdf_optin_s;

   // Status register image, LSB is gate of channel 1
   typedef struct packed {
      logic       pwrup;
      logic       half;
      logic [1:0] pend;
      logic [1:0] block;
      logic [1:0] err;
      logic [1:0] light;
      logic [1:0] gate;
   } gdf_stat_s;

endpackage : gdf_pkg

// ===== src/gdf_sync.sv
`timescale 1ns/1ps

// ==========================================================
// Two-stage synchroniser for pin inputs
module gdf_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk, // Device clock
   input  wire logic         rst,  // Sync reset
   input  wire logic [W-1:0] d,    // Async pins
   output logic      [W-1:0] q     // Synchronised
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : gdf_sync

// ===== src/gdf_timer.sv
`timescale 1ns/1ps

// ==========================================================
// One-shot timer: busy for LEN cycles after start
module gdf_timer #(
   parameter  int LEN = 1,
   localparam int W   = $clog2(LEN + 1)
) (
   input  wire logic         mclk,   // Device clock
   input  wire logic         rst,    // Sync reset
   input  wire logic         start,  // Restart pulse
   output logic              busy,   // Running
   output logic      [W-1:0] elapsed // Cycles since start
);

   generate
      if (LEN < 1) begin : g_bad
         $error("gdf_timer: LEN must be at least one");
      end
   endgenerate

   // A start while running restarts, so a held cause extends the time
   always_ff @(posedge mclk) begin
      if (rst) begin
         busy    <= 1'b0;
         elapsed <= '0;
      end else if (start) begin
         busy    <= 1'b1;
         elapsed <= '0;
      end else if (busy) begin
         if (elapsed == W'(LEN - 1)) begin
            busy <= 1'b0;
         end else begin
            elapsed <= elapsed + 1'b1;
         end
      end
   end

endmodule : gdf_timer

// ===== tb/gdf_host.sv
`timescale 1ns/1ps

// ==========================================================
// Host model: drives the optical pair, watches status lights
module gdf_host #(
   parameter int TRIP_CYC = 300
) (
   input  wire logic       mclk,  // Device clock
   input  wire logic       rst,   // Sync reset
   input  wire logic       obey,  // Honour fault shutdown
   input  wire logic [1:0] want,  // Requested drive levels
   input  wire logic [1:0] light, // Status lights
   output logic      [1:0] drive  // Optical drives
);
   int   low_q;
   logic trip_q;
   // Dark time, so a short ack is never taken for a fault
   always_ff @(posedge mclk) begin
      if (rst || &light) low_q <= 0;
      else low_q <= low_q + 1;
   end
   // Any fault report switches both drives off for good
   always_ff @(posedge mclk) begin
      if (rst) trip_q <= 1'b0;
      else if (obey && low_q > TRIP_CYC) trip_q <= 1'b1;
   end
   // Drives change only just after an edge
   always_ff @(posedge mclk) begin
      drive <= rst ? 2'b00 : want & {2{!trip_q}};
   end
endmodule : gdf_host

// ===== tb/test_gdf_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end

module test_gdf_top;
   import gdf_pkg::*;
   logic        mclk = 0, rst = 1, jmp = 0, obey = 0, psel = 0, penable = 0, pwrite = 0;
   logic [1:0]  want = 0, desat = 0, uvlo = 0, drive, gate_on, light;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, err;
   int          n_errors = 0, n_tests = 0, cyc = 0, c;

   // ==========================================================
   // Clock, device and host model
   always #4 mclk = ~mclk;
   // Release window is left to follow the force-off time (400 cycles here)
   gdf_top #(.BLOCK_CYC(2000), .REPORT_CYC(1200), .XOFF_CYC(800),
      .ERRCLR_CYC(350), .PWRUP_CYC(800)) i_dut (.mclk(mclk), .rst(rst),
      .optical_drive_in_first(drive[0]), .optical_drive_in_second(drive[1]),
      .operating_select_jumper(jmp), .desat_in(desat), .uvlo_in(uvlo), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .gate_on(gate_on), .status_light(light));
   gdf_host i_host (.mclk(mclk), .rst(rst), .obey(obey), .want(want), .light(light),
      .drive(drive));

   // Hang guard, well above the whole sequence
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   // ==========================================================
   // Bounded wait on gates (sel 0) or lights (sel 1)
   task automatic wf(input bit sel, input logic [1:0] v, input int n);
      c = 0;
      do begin
         @(posedge mclk);
         c++;
      end while ((sel ? light : gate_on) !== v && c < n);
   endtask : wf

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   // ==========================================================
   // Scenarios
   task automatic t_direct;
      want <= 2'b01;
      wf(1, 2'b10, 10);
      wf(1, 2'b11, 200);
      `CHK(c inside {[120:128]}, 1'b1)
      `CHK(gate_on, 2'b01)
      apb(0, 12'h000, 0);
      `CHK(rd, 32'h0000_0000)
      want <= 2'b11;
      apb(1, 12'h000, 32'h0000_0001);
      apb(0, 12'h004, 0);
      `CHK(rd[11:0], 12'h004)
      apb(1, 12'h008, 32'h0000_0001);
      `CHK(err, 1'b1)
      apb(0, 12'h008, 0);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      apb(1, 12'h000, 0);
      wf(0, 2'b11, 10);
      `CHK(gate_on, 2'b11)
      $display("direct done");
   endtask : t_direct

   // Desat fault on channel 1 while channel 2 runs
   task automatic t_fault;
      int i, t0, t1, t2, d0;
      logic g;
      repeat (100) @(posedge mclk);
      desat <= 2'b01;
      repeat (50) @(posedge mclk);
      desat <= 2'b00;
      repeat (10) @(posedge mclk);
      `CHK(gate_on, 2'b11)
      repeat (600) @(posedge mclk);
      desat <= 2'b01;
      wf(0, 2'b10, 10);
      `CHK(gate_on, 2'b10)
      desat <= 2'b00;
      d0 = cyc;
      repeat (20) @(posedge mclk);
      `CHK(light, 2'b11)
      want <= 2'b10;
      t0 = 0;
      t1 = 0;
      t2 = 0;
      g = 0;
      for (i = 1; i < 1400; i++) begin
         @(posedge mclk);
         if (i == 100) want <= 2'b11;
         g |= gate_on[0];
         if (!gate_on[1] && t0 == 0) t0 = i;
         if (gate_on[1] && t0 > 0 && t1 == 0) t1 = i;
         if (i > 10 && light[0] && t2 == 0) t2 = i;
      end
      `CHK(g, 1'b0)
      `CHK(t0 inside {[798:810]}, 1'b1)
      `CHK((t1 - t0) inside {[396:404]}, 1'b1)
      `CHK(t2 inside {[1198:1210]}, 1'b1)
      apb(0, 12'h004, 0);
      `CHK(rd[7:4], 4'b0100)
      while (cyc - d0 < 1900) @(posedge mclk);
      `CHK(gate_on[0], 1'b0)
      wf(0, 2'b11, 300);
      `CHK(gate_on, 2'b11)
      $display("fault done");
   endtask : t_fault

   // Half-bridge decode and dead time
   task automatic t_half;
      jmp <= 1'b1;
      want <= 2'b10;
      wf(0, 2'b01, 500);
      `CHK(gate_on, 2'b01)
      want <= 2'b11;
      wf(0, 2'b00, 6);
      `CHK(gate_on, 2'b00)
      wf(0, 2'b10, 500);
      `CHK(c inside {[372:378]}, 1'b1)
      want <= 2'b01;
      wf(0, 2'b00, 6);
      `CHK(gate_on, 2'b00)
      $display("half done");
   endtask : t_half

   // Undervoltage on channel 2, host obeys the report
   task automatic t_uv;
      jmp <= 1'b0;
      want <= 2'b11;
      wf(0, 2'b11, 600);
      obey <= 1'b1;
      uvlo <= 2'b10;
      wf(0, 2'b01, 10);
      `CHK(gate_on, 2'b01)
      uvlo <= 2'b00;
      want <= 2'b01;
      repeat (400) @(posedge mclk);
      `CHK({light[1], drive, gate_on}, 5'b0_0000)
      $display("undervoltage done");
   endtask : t_uv

   // ==========================================================
   // Verdict and main sequence
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      wf(1, 2'b11, 2000);
      `CHK(c inside {[795:810]}, 1'b1)
      `CHK(light, 2'b11)
      t_direct();
      t_fault();
      t_half();
      t_uv();
      stop_test();
   end
endmodule : test_gdf_top
